// ### design/sctr_pkg.sv
// package of widths, cycle kinds and carriers for the synchronous cache tag memory
package sctr_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int SCTR_ENTRIES = 8192;
  localparam int SCTR_IDX_W   = 13;
  localparam int SCTR_TAG_W   = 15;
  localparam int SCTR_PART_W  = 2;

  // ****************************************************************
  // bulk invalidation sequencing
  // ****************************************************************
  localparam int               SCTR_CLEAR_ALL_VALID_N_EDGES = 4;
  localparam logic [SCTR_PART_W-1:0] SCTR_PART_FIRST = 2'h0;
  localparam logic [SCTR_PART_W-1:0] SCTR_PART_STEP  = 2'h1;

  // ****************************************************************
  // cycle kinds and carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    SCTR_OP_IDLE,
    SCTR_OP_COMPARE,
    SCTR_OP_READ,
    SCTR_OP_WRITE,
    SCTR_OP_CLEAR_ALL_VALID_N
  } sctr_op_t;

  typedef struct packed {
    logic     sel;
    sctr_op_t op;
  } sctr_ctl_t;

  typedef struct packed {
    logic match;
    logic flag;
  } sctr_flags_t;

endpackage

// ### design/sctr_tag_ram.sv
// synchronous cache tag memory with compare, access and bulk invalidate
// ****************************************************************
// tag memory top
// ****************************************************************
module sctr_tag_ram
  import sctr_pkg::*;
#(
  parameter int IDX_W = SCTR_IDX_W,
  parameter int TAG_W = SCTR_TAG_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [IDX_W-1:0] entry_index,
  input  wire logic             mode_select_n,
  input  wire logic             tag_store_enable_n,
  input  wire logic             clear_all_valid_n,
  input  wire logic             select_low_a,
  input  wire logic             select_high,
  input  wire logic             select_low_b,
  input  wire logic             output_enable_n,
  input  wire logic [TAG_W-1:0] tag_data_in,
  output logic      [TAG_W-1:0] tag_data_out,
  output logic                  tag_data_oe,
  input  wire logic             entry_flag_in,
  output logic                  entry_flag_out,
  output logic                  entry_flag_oe,
  output logic                  match_out,
  output logic                  match_oe
);

  localparam int SUB_W   = IDX_W - SCTR_PART_W;
  localparam int PARTS   = 1 << SCTR_PART_W;
  localparam int SUB_N   = 1 << SUB_W;
  localparam int ENTRIES = 1 << IDX_W;

  // ****************************************************************
  // storage
  // ****************************************************************
  // valid bits are split into four banks so that each invalidate edge
  // clears one bank; this keeps the clear fan-out to a quarter of the array
  logic [TAG_W-1:0] tag_mem [ENTRIES];
  logic [SUB_N-1:0] valid_q [PARTS];

  logic [SCTR_PART_W-1:0] part_idx;
  logic [SUB_W-1:0]       sub_idx;
  logic [TAG_W-1:0]       rd_tag;
  logic                   rd_valid;
  logic                   hit;
  logic                   sel_in;
  logic                   mem_we;
  logic                   clr_now;

  // ****************************************************************
  // control and result state
  // ****************************************************************
  sctr_ctl_t              ctl_d, ctl_q;
  sctr_flags_t            res_d, res_q;
  logic [TAG_W-1:0]       data_d, data_q;
  logic [SCTR_PART_W-1:0] part_d, part_q;

  // ****************************************************************
  // request decode
  // ****************************************************************
  // the array is read at the raw index so that the result lands in the
  // output registers at the very edge that takes the request; no extra
  // index register is needed and the answer is on the outputs right after that edge
  always_comb begin
    part_idx = entry_index[IDX_W-1 -: SCTR_PART_W];
    sub_idx  = entry_index[SUB_W-1:0];
    rd_tag   = tag_mem[entry_index];
    rd_valid = valid_q[part_idx][sub_idx];
    hit      = rd_valid && (rd_tag == tag_data_in);
    sel_in   = !select_low_a && select_high && !select_low_b;

    // invalidate outranks select and mode
    if (!clear_all_valid_n) begin
      ctl_d.op = SCTR_OP_CLEAR_ALL_VALID_N;
    end else if (!sel_in) begin
      ctl_d.op = SCTR_OP_IDLE;
    end else if (mode_select_n) begin
      ctl_d.op = SCTR_OP_COMPARE;
    end else if (tag_store_enable_n) begin
      ctl_d.op = SCTR_OP_READ;
    end else begin
      ctl_d.op = SCTR_OP_WRITE;
    end
    ctl_d.sel = sel_in;
    mem_we    = (ctl_d.op == SCTR_OP_WRITE);
    clr_now   = (ctl_d.op == SCTR_OP_CLEAR_ALL_VALID_N);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= '{sel: 1'h0, op: SCTR_OP_IDLE};
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ****************************************************************
  // result registers
  // ****************************************************************
  // idle and write cycles keep the last flag and data, so a deselected
  // gap without an invalidate never disturbs what the last valid read left for the bus
  always_comb begin
    res_d  = res_q;
    data_d = data_q;
    case (ctl_d.op)
      SCTR_OP_CLEAR_ALL_VALID_N: begin
        res_d.match = 1'h0;
        res_d.flag  = 1'h0;
      end
      SCTR_OP_COMPARE: begin
        res_d.match = hit;
        res_d.flag  = rd_valid;
      end
      SCTR_OP_READ: begin
        res_d.match = 1'h1;
        res_d.flag  = rd_valid;
        data_d      = rd_tag;
      end
      SCTR_OP_WRITE: begin
        res_d.match = 1'h1;
      end
      default: begin
        res_d = res_q;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_q  <= '0;
      data_q <= '0;
    end else begin
      res_q  <= res_d;
      data_q <= data_d;
    end
  end

  // ****************************************************************
  // bulk invalidate bank pointer
  // ****************************************************************
  // bank pointer restarts whenever invalidate is seen high, so a later
  // rise always ends the cycle and the next fall starts again at bank 0;
  // a burst shorter than four edges leaves the upper banks untouched
  always_comb begin
    if (clr_now) begin
      part_d = part_q + SCTR_PART_STEP;
    end else begin
      part_d = SCTR_PART_FIRST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      part_q <= SCTR_PART_FIRST;
    end else begin
      part_q <= part_d;
    end
  end

  // ****************************************************************
  // array writes
  // ****************************************************************
  // the array has no reset: contents are meaningless until invalidated
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      tag_mem[entry_index] <= tag_data_in;
    end
  end

  for (genvar p = 0; p < PARTS; p++) begin : g_bank
    always_ff @(posedge sys_clk) begin
      if (clr_now && (part_q == SCTR_PART_W'(p))) begin
        valid_q[p] <= '0;
      end else if (mem_we && (part_idx == SCTR_PART_W'(p))) begin
        valid_q[p][sub_idx] <= entry_flag_in;
      end
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // output enable gates only the two-way pins and works without the clock
  assign tag_data_out   = data_q;
  assign tag_data_oe    = !output_enable_n && (ctl_q.op == SCTR_OP_READ);
  assign entry_flag_out = res_q.flag;
  assign entry_flag_oe  = !output_enable_n && ctl_q.sel &&
                          (ctl_q.op != SCTR_OP_WRITE) && (ctl_q.op != SCTR_OP_IDLE);
  assign match_out      = res_q.match;
  assign match_oe       = ctl_q.sel;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_hit_needs_valid: assert property (
    (clear_all_valid_n && sel_in && mode_select_n) |=> (match_out == $past(hit)))
    else $error("compare result does not follow stored tag and valid bit");

  a_access_match_high: assert property (
    (clear_all_valid_n && sel_in && !mode_select_n) |=> match_out)
    else $error("match not high in access mode");

  a_clear_all_valid_n_forces_low: assert property (
    !clear_all_valid_n |=> (!match_out && !entry_flag_out))
    else $error("invalidate did not force match and flag low");

  a_four_edge_clear: assert property (
    (!clear_all_valid_n [*4] ##1 (clear_all_valid_n && sel_in && mode_select_n))
      |=> (!match_out && !entry_flag_out))
    else $error("entry still valid after four invalidate edges");

  a_oe_floats_pins: assert property (
    output_enable_n |-> (!tag_data_oe && !entry_flag_oe))
    else $error("two-way pin driven while output enable high");

  a_select_gates_match: assert property (
    ##1 (match_oe == $past(!select_low_a && select_high && !select_low_b)))
    else $error("match drive does not follow registered selects");

  a_read_returns_entry: assert property (
    (clear_all_valid_n && sel_in && !mode_select_n && tag_store_enable_n)
      |=> ((tag_data_out == $past(rd_tag)) && (entry_flag_out == $past(rd_valid))))
    else $error("read data is not the addressed entry");

  a_data_holds: assert property (
    !(clear_all_valid_n && sel_in && !mode_select_n && tag_store_enable_n)
      |=> $stable(tag_data_out))
    else $error("read data changed without a read cycle");

  a_compare_no_write: assert property (
    (mode_select_n || !clear_all_valid_n || !sel_in) |-> !mem_we)
    else $error("array written outside a tag write cycle");

  a_write_then_read: assert property (
    ((ctl_d.op == SCTR_OP_WRITE) ##1 ((ctl_d.op == SCTR_OP_READ) &&
      (entry_index == $past(entry_index))))
      |=> ((tag_data_out == $past(tag_data_in, 2)) && (entry_flag_out == $past(entry_flag_in, 2))))
    else $error("written tag or valid bit not read back");

  a_desel_floats: assert property (
    !sel_in |=> (!match_oe && !tag_data_oe && !entry_flag_oe))
    else $error("output driven after a deselected edge");

  a_bank_restart: assert property (
    clear_all_valid_n |=> (part_q == SCTR_PART_FIRST))
    else $error("bank pointer not restarted after invalidate release");

  a_bank_advance: assert property (
    !clear_all_valid_n |=> (part_q == $past(part_q) + SCTR_PART_STEP))
    else $error("bank pointer did not step on an invalidate edge");

  a_read_drives_pins: assert property (
    (clear_all_valid_n && sel_in && !mode_select_n && tag_store_enable_n && !output_enable_n)
      |=> (output_enable_n || (tag_data_oe && entry_flag_oe)))
    else $error("read with output enable low left pins floating");

  a_miss_when_invalid: assert property (
    (clear_all_valid_n && sel_in && mode_select_n && !rd_valid) |=> !match_out)
    else $error("hit reported for an invalid entry");

  a_compare_shows_flag: assert property (
    (clear_all_valid_n && sel_in && mode_select_n) |=> (entry_flag_out == $past(rd_valid)))
    else $error("compare does not show stored valid bit");

  c_compare_hit: cover property ((ctl_q.op == SCTR_OP_COMPARE) && match_out);
  c_compare_miss: cover property ((ctl_q.op == SCTR_OP_COMPARE) && !match_out);
  c_full_clear_all_valid_n_desel: cover property ((!clear_all_valid_n && !sel_in) [*4]);
  c_write_read: cover property ((ctl_q.op == SCTR_OP_WRITE) ##1 (ctl_q.op == SCTR_OP_READ));
  c_clear_all_valid_n_compare: cover property (!clear_all_valid_n [*4] ##1 (clear_all_valid_n && sel_in && mode_select_n));

endmodule // sctr_tag_ram

// ### tb/sctr_ctl_model.sv
// controller-side pin driver and bus resolver for the cache tag memory
module sctr_ctl_model
  import sctr_pkg::*;
(
  input  wire logic                  sys_clk,
  output logic [SCTR_IDX_W-1:0]      entry_index,
  output logic                       mode_select_n,
  output logic                       tag_store_enable_n,
  output logic                       clear_all_valid_n,
  output logic                       select_low_a,
  output logic                       select_high,
  output logic                       select_low_b,
  output logic                       output_enable_n,
  output logic [SCTR_TAG_W-1:0]      tag_bus,
  output logic                       flag_pin,
  input  wire logic [SCTR_TAG_W-1:0] tag_data_out,
  input  wire logic                  tag_data_oe,
  input  wire logic                  entry_flag_out,
  input  wire logic                  entry_flag_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [SCTR_TAG_W-1:0] tag_drv = 15'h0000;
  logic [SCTR_TAG_W-1:0] tag_last = 15'h0000;
  logic                  flag_drv = 1'h0;
  logic                  flag_last = 1'h0;
  // a released line shows the inverse of its last level, never a stale copy
  assign tag_bus  = tag_data_oe ? tag_data_out : (output_enable_n ? tag_drv : ~tag_last);
  assign flag_pin = entry_flag_oe ? entry_flag_out : (output_enable_n ? flag_drv : ~flag_last);
  always @(posedge sys_clk) begin
    tag_last  <= tag_bus;
    flag_last <= flag_pin;
  end
  initial begin
    {mode_select_n, tag_store_enable_n, clear_all_valid_n, output_enable_n} = 4'hF;
    {select_low_a, select_high, select_low_b} = 3'h5;
    entry_index = 13'h0000;
  end
  // c = {mode_n, store_n, clear_n, selected, oe_n}; one request per edge
  task automatic op(input logic [12:0] idx, input logic [14:0] tag, input logic flag, input logic [4:0] c);
    entry_index        = idx;
    tag_drv            = tag;
    flag_drv           = flag;
    mode_select_n      = c[4];
    tag_store_enable_n = c[3];
    clear_all_valid_n  = c[2];
    select_low_a       = ~c[1];
    select_high        = c[1];
    select_low_b       = ~c[1];
    output_enable_n    = c[0];
    @(posedge sys_clk);
    #1;
  endtask
endmodule // sctr_ctl_model

// ### tb/testbench.sv
// self-checking bench for the cache tag memory
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
module testbench
  import sctr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // request codes {mode_n, store_n, clear_n, selected, oe_n}
  // ****************************************************************
  localparam logic [4:0] CMP = 5'h1F, CMPW = 5'h17, WR = 5'h07, RD = 5'h0E, RDZ = 5'h0F;
  localparam logic [4:0] INV = 5'h1B, INVD = 5'h19, IDLE = 5'h1D;
  logic                  sys_clk = 1'h0;
  logic                  rst = 1'h1;
  logic [SCTR_IDX_W-1:0] idx;
  logic                  ms_n, ws_n, cv_n, sa, sh, sb, oe_n, fpin, fout, foe, tdoe, mo, moe;
  logic [SCTR_TAG_W-1:0] tbus, tdo;
  int                    err_total = 0;
  int                    checked = 0;
  int                    cycles = 0;
  always #4 sys_clk = ~sys_clk;
  sctr_ctl_model i_ctl (.sys_clk(sys_clk), .entry_index(idx), .mode_select_n(ms_n),
    .tag_store_enable_n(ws_n), .clear_all_valid_n(cv_n), .select_low_a(sa), .select_high(sh),
    .select_low_b(sb), .output_enable_n(oe_n), .tag_bus(tbus), .flag_pin(fpin),
    .tag_data_out(tdo), .tag_data_oe(tdoe), .entry_flag_out(fout), .entry_flag_oe(foe));
  sctr_tag_ram i_dut (.sys_clk(sys_clk), .rst(rst), .entry_index(idx), .mode_select_n(ms_n),
    .tag_store_enable_n(ws_n), .clear_all_valid_n(cv_n), .select_low_a(sa), .select_high(sh),
    .select_low_b(sb), .output_enable_n(oe_n), .tag_data_in(tbus), .tag_data_out(tdo),
    .tag_data_oe(tdoe), .entry_flag_in(fpin), .entry_flag_out(fout), .entry_flag_oe(foe),
    .match_out(mo), .match_oe(moe));
  function automatic logic [12:0] ix(input int k);
    return {k[1:0], 11'h555};
  endfunction
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_clear_all_valid_n(input logic [4:0] c);
    for (int e = 0; e < SCTR_CLEAR_ALL_VALID_N_EDGES; e++) begin
      i_ctl.op(13'h0000, 15'h0000, 1'h1, c);
      `CHK("clear_all_valid_n match", 1'h0, mo)
      `CHK("clear_all_valid_n flag", 1'h0, fout)
      `CHK("clear_all_valid_n bus oe", 1'h0, tdoe)
    end
    i_ctl.op(ix(1), 15'h7FFE, 1'h0, CMP);
    `CHK("clear_all_valid_n end miss", 2'h1, {mo, moe})
  endtask
  task automatic t_write_read();
    for (int k = 0; k < 4; k++) begin
      i_ctl.op(ix(k), 15'h7FFF - 15'(k), 1'h1, WR);
      `CHK("write match", 1'h1, mo)
      `CHK("write flag oe", 1'h0, foe)
    end
    for (int k = 3; k >= 0; k--) begin
      i_ctl.op(ix(k), 15'h0000, 1'h0, RD);
      `CHK("read tag", 15'h7FFF - 15'(k), tdo)
      `CHK("read flag", 1'h1, fout)
      `CHK("read oes", 2'h3, {tdoe, foe})
      `CHK("read match", 1'h1, mo)
    end
  endtask
  task automatic t_compare();
    for (int k = 0; k < 4; k++) begin
      i_ctl.op(ix(k), 15'h7FFF - 15'(k), 1'h0, CMPW);
      `CHK("hit", 2'h3, {mo, moe})
      i_ctl.op(ix(k), 15'h7FFF - 15'(k + 1), 1'h0, CMP);
      `CHK("miss", 1'h0, mo)
    end
    i_ctl.op(ix(0), 15'h0000, 1'h0, RD);
    `CHK("compare kept tag", 15'h7FFF, tdo)
    `CHK("compare kept flag", 1'h1, fout)
    i_ctl.op(ix(1), 15'h0000, 1'h0, RD);
    `CHK("last read", 15'h7FFE, tdo)
    i_ctl.output_enable_n = 1'h1;
    #1;
    `CHK("async oe", 2'h0, {tdoe, foe})
  endtask
  task automatic t_deselect();
    i_ctl.op(ix(0), 15'h0000, 1'h0, IDLE);
    `CHK("deselect oes", 3'h0, {moe, tdoe, foe})
    i_ctl.op(ix(0), 15'h0000, 1'h0, RDZ);
    `CHK("oe high", 3'h4, {moe, tdoe, foe})
  endtask
  task automatic t_after_clear_all_valid_n();
    for (int k = 0; k < 4; k++) begin
      i_ctl.op(ix(k), 15'h7FFF - 15'(k), 1'h0, CMP);
      `CHK("cleared miss", 1'h0, mo)
      i_ctl.op(ix(k), 15'h0000, 1'h0, RD);
      `CHK("cleared flag", 1'h0, fout)
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard: the whole sequence needs well under 200 edges
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    t_clear_all_valid_n(INV);
    t_write_read();
    t_compare();
    t_deselect();
    t_clear_all_valid_n(INVD);
    t_after_clear_all_valid_n();
    wrap_up();
  end
endmodule // testbench
